// file: rtl/thr_pkg.sv
// Purpose: Shared constants, types and register map of the slope thermostat
// Assumes: 250 MHz core clock, slow and fast ticks made by dividers
// Notes:   Resistances are kept scaled down by one hundred
package thr_pkg;

  // Clock rates and tick dividers
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned SLOW_HZ        = 32_768;
  localparam int unsigned FAST_HZ        = 1_000_000;
  localparam int unsigned SLOW_DIV       = CLK_HZ / SLOW_HZ;
  localparam int unsigned FAST_DIV       = CLK_HZ / FAST_HZ;

  // Times in their own units, and tick counts derived from them
  localparam int unsigned WAKE_PERIOD_MS = 5000;
  localparam int unsigned LED_HOLD_MS    = 500;
  localparam int unsigned CHARGE_US      = 5000;
  localparam int unsigned WAKE_TICKS     = WAKE_PERIOD_MS * SLOW_HZ / 1000;
  localparam int unsigned LED_TICKS      = LED_HOLD_MS * SLOW_HZ / 1000;
  localparam int unsigned CHARGE_TICKS   = CHARGE_US * (FAST_HZ / 1_000_000);

  // Counter and data widths
  localparam int unsigned CNT0_W         = 18;
  localparam int unsigned CNT1_W         = 16;
  localparam int unsigned RES_W          = 16;
  localparam int unsigned DIV_W          = 24;
  localparam int unsigned NUM_CH         = 3;
  localparam int unsigned TABLE_LEN      = 36;

  // Measurement channels
  localparam logic [1:0]  CH_THERM       = 2'h0;
  localparam logic [1:0]  CH_POT         = 2'h1;
  localparam logic [1:0]  CH_REF         = 2'h2;

  // Conversion constants
  localparam logic [7:0]  TEMP_BASE_F    = 8'h3C;
  localparam logic [7:0]  SETPT_BASE_F   = 8'h41;
  localparam logic [7:0]  SETPT_MAX_F    = 8'h5A;
  localparam logic [RES_W-1:0] SETPT_OFFSET = 16'h002F;
  localparam int unsigned SETPT_SHIFT    = 2;
  localparam logic [7:0]  TOL_F          = 8'h01;
  localparam logic [DIV_W-1:0] RREF_SCALED = 24'h000064;
  localparam logic [RES_W-1:0] DEF_TABLE_TOP  = 16'h00C8;
  localparam logic [RES_W-1:0] DEF_TABLE_STEP = 16'h0003;

  // Register map, byte addresses
  localparam int unsigned ADDR_W         = 12;
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_STATUS     = 12'h004;
  localparam logic [11:0] REG_RESULT     = 12'h008;
  localparam logic [11:0] REG_RES        = 12'h00C;
  localparam logic [11:0] REG_TIME0      = 12'h010;
  localparam logic [11:0] REG_TIME1      = 12'h014;
  localparam logic [11:0] REG_TABLE      = 12'h100;
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_KICK_BIT  = 1;

  // Controller phases
  typedef enum logic [2:0] {
    PH_DEEP_WAIT,
    PH_CHARGE,
    PH_DISCHARGE,
    PH_DIVIDE,
    PH_LOOKUP,
    PH_DECIDE,
    PH_LED_HOLD
  } thr_phase_type;

  // APB request and answer, with the bus's own signal names
  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
  } thr_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } thr_apb_rsp_type;

  // Resistor network pins
  typedef struct packed {
    logic              driveLine;
    logic [NUM_CH-1:0] sensOut;
    logic [NUM_CH-1:0] sensOeN;
  } thr_pins_type;

  // Indicator outputs
  typedef struct packed {
    logic sysOn;
    logic heat;
    logic cool;
  } thr_led_type;

  typedef logic [TABLE_LEN-1:0][RES_W-1:0] thr_table_type;

  // Default table, falling resistance per degree for an NTC part
  function automatic thr_table_type thr_def_table();
    thr_table_type t;
    t = '0;
    for (int i = 0; i < TABLE_LEN; i++) begin
      t[i] = DEF_TABLE_TOP - RES_W'(DEF_TABLE_STEP * RES_W'(i));
    end
    return t;
  endfunction

endpackage

// file: rtl/thr_tick_div.sv
// Purpose: Divides the core clock into a one-cycle enable pulse
// Assumes: DIV of at least one
// Notes:   Pulse is high for one core cycle in every DIV
`timescale 1ns/1ps
module thr_tick_div #(
  parameter int unsigned DIV = 250
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Tick out
  output logic      tick
);
  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } thr_div_state_type;

  thr_div_state_type s;
  thr_div_state_type next_s;

  // Free-running count wraps at DIV-1
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.count >= 32'(DIV - 1)) begin
      next_s.count = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.count = s.count + 32'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule

// file: rtl/thr_slope_ctrl.sv
// Purpose: Slope-conversion thermostat controller with an APB register file
// Assumes: Comparator and sense pins synchronous to core_clk; pull-ups outside
// Notes:   Contract
// Contract
// R1 - One measure-and-decide cycle per five-second wake; deep sleep between cycles.
// R2 - Indicators stay on half a second, then off and back to sleep.
// R3 - Temperature at setpoint lights system-on only; else system-on plus heat or cool.
// R4 - Within one degree either side counts as matched; heat/cool only outside.
// R5 - Long waits use slow ticks; discharge timing uses fast ticks.
// R6 - Channel zero times deep-sleep waits; channel one times discharge only; code also times the charge interval on channel one.
// R7 - Each timer wake clears the sleep request and resumes the waiting step; code clears lightSleep only after the reference discharge.
// R8 - Measure thermistor, pot and reference, then scale by reference time ratio.
// R9 - Temperature is sixty degrees plus the matching per-degree table index.
// R10 - Resistances are held divided by one hundred; 10 kOhm reads 100.
// R11 - Setpoint is pot minus 47, shifted right by two, from 65 to 90.
// R12 - Idle: drive line high, all sense lines released as inputs.
// R13 - Charge high, clear and start counter at drive low, capture on comparator fall.
// R14 - Resistance is reference times unknown time divided by reference time.
`timescale 1ns/1ps
module thr_slope_ctrl
  import thr_pkg::*;
#(
  parameter int unsigned WAKE_TICKS_P   = thr_pkg::WAKE_TICKS,
  parameter int unsigned LED_TICKS_P    = thr_pkg::LED_TICKS,
  parameter int unsigned CHARGE_TICKS_P = thr_pkg::CHARGE_TICKS,
  parameter int unsigned SLOW_DIV_P     = thr_pkg::SLOW_DIV,
  parameter int unsigned FAST_DIV_P     = thr_pkg::FAST_DIV
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  // APB register bus
  input  wire thr_pkg::thr_apb_req_type apbReq,
  output      thr_pkg::thr_apb_rsp_type apbRsp,
  // Resistor network and comparator
  input  wire logic [thr_pkg::NUM_CH-1:0] sensIn,
  input  wire logic                    comparatorOutput,
  output      thr_pkg::thr_pins_type   pins,
  // Indicators
  output      thr_pkg::thr_led_type    leds
);
  import thr_pkg::*;

  typedef struct packed {
    thr_phase_type                    phase;
    logic [1:0]                       chan;
    logic                             deepSleep;
    logic                             lightSleep;
    logic [CNT0_W-1:0]                chan0Count;
    logic [CNT1_W-1:0]                timerCount;
    logic [NUM_CH-1:0][CNT1_W-1:0]    capTime;
    logic                             compPrev;
    logic                             divSel;
    logic [4:0]                       divStep;
    logic [CNT1_W-1:0]                divRem;
    logic [DIV_W-1:0]                 divQuo;
    logic [RES_W-1:0]                 rTherm;
    logic [RES_W-1:0]                 rPot;
    logic [5:0]                       lookIdx;
    logic [7:0]                       tempF;
    logic [7:0]                       setF;
    thr_led_type                      led;
    logic                             enable;
    logic                             kick;
    thr_table_type                    ntcTable;
    logic [31:0]                      rdData;
    logic                             slvErr;
  } thr_state_type;

  localparam thr_state_type RESET_STATE = '{
    phase:     PH_DEEP_WAIT,
    deepSleep: 1'b1,
    enable:    1'b1,
    ntcTable:  thr_def_table(),
    default:   '0
  };

  thr_state_type s;
  thr_state_type next_s;
  logic          slowTick;
  logic          fastTick;

  // Slow auxiliary tick for long waits, fast sub-clock tick for discharge
  thr_tick_div #(.DIV(SLOW_DIV_P)) slowDiv (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tick     (slowTick)
  );

  thr_tick_div #(.DIV(FAST_DIV_P)) fastDiv (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tick     (fastTick)
  );

  // Decodes a table address; returns valid flag above the index
  function automatic logic [6:0] tableIndex(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - REG_TABLE;
    if (a >= REG_TABLE && off[1:0] == 2'h0 && off[ADDR_W-1:2] < (ADDR_W-2)'(TABLE_LEN)) begin
      return {1'b1, off[7:2]};
    end
    return 7'h00;
  endfunction

  // Read mux; bit 32 flags an unmapped address
  function automatic logic [32:0] readWord(input thr_state_type st,
                                           input logic [ADDR_W-1:0] a,
                                           input logic [NUM_CH-1:0] pinIn,
                                           input logic comp);
    logic [6:0] ti;
    ti = tableIndex(a);
    if (a == REG_CTRL) begin
      return {1'b0, 30'h0, st.kick, st.enable};
    end else if (a == REG_STATUS) begin
      return {1'b0, 20'h0, comp, pinIn, 1'b0, st.chan, st.lightSleep, st.deepSleep,
              3'(st.phase)};
    end else if (a == REG_RESULT) begin
      return {1'b0, 13'h0, st.led.cool, st.led.heat, st.led.sysOn, st.setF, st.tempF};
    end else if (a == REG_RES) begin
      return {1'b0, st.rPot, st.rTherm};
    end else if (a == REG_TIME0) begin
      return {1'b0, st.capTime[CH_POT], st.capTime[CH_THERM]};
    end else if (a == REG_TIME1) begin
      return {1'b0, 16'h0, st.capTime[CH_REF]};
    end else if (ti[6]) begin
      return {1'b0, 16'h0, st.ntcTable[ti[5:0]]};
    end
    return {1'b1, 32'h0};
  endfunction

  // Next-state logic: register file, sequencer, divider and decision
  always_comb begin
    logic [32:0]       rd;
    logic [6:0]        ti;
    logic [CNT1_W:0]   trial;
    logic [RES_W-1:0]  quo16;
    logic [RES_W-1:0]  potDiff;
    logic [7:0]        steps;
    logic              wakeEvent;
    rd = '0;
    ti = '0;
    trial = '0;
    quo16 = '0;
    potDiff = '0;
    steps = '0;
    wakeEvent = 1'b0;
    next_s = s;
    next_s.compPrev = comparatorOutput;

    // APB setup phase latches read data and error for the access phase
    if (apbReq.psel && !apbReq.penable) begin
      rd = readWord(s, apbReq.paddr, sensIn, comparatorOutput);
      next_s.rdData = apbReq.pwrite ? 32'h0 : rd[31:0];
      next_s.slvErr = rd[32];
    end
    // APB write takes effect at the access edge
    if (apbReq.psel && apbReq.penable && apbReq.pwrite) begin
      ti = tableIndex(apbReq.paddr);
      if (apbReq.paddr == REG_CTRL) begin
        next_s.enable = apbReq.pwdata[CTRL_EN_BIT];
        next_s.kick   = apbReq.pwdata[CTRL_KICK_BIT];
      end else if (ti[6]) begin
        next_s.ntcTable[ti[5:0]] = apbReq.pwdata[RES_W-1:0];
      end
    end

    case (s.phase)
      // Deep sleep: channel zero counts slow ticks toward the wake event
      PH_DEEP_WAIT: begin
        if (!s.enable) begin
          next_s.chan0Count = '0;
        end else if (slowTick) begin                                  // R5 R6
          if (s.chan0Count >= CNT0_W'(WAKE_TICKS_P - 1)) begin
            wakeEvent = 1'b1;                                         // R1
          end else begin
            next_s.chan0Count = s.chan0Count + CNT0_W'(1);
          end
        end
        // A software kick wakes at once and is consumed here
        if (s.enable && s.kick) begin
          wakeEvent = 1'b1;
          next_s.kick = 1'b0;
        end
        if (wakeEvent) begin
          next_s.deepSleep  = 1'b0;                                   // R7
          next_s.chan0Count = '0;
          next_s.chan       = CH_THERM;                               // R8
          next_s.timerCount = '0;
          next_s.lightSleep = 1'b1;
          next_s.phase      = PH_CHARGE;
        end
      end
      // Charge the capacitor high; channel one times the charge interval
      PH_CHARGE: begin
        if (fastTick) begin                                           // R5
          if (s.timerCount >= CNT1_W'(CHARGE_TICKS_P - 1)) begin
            next_s.timerCount = '0;                                   // R13
            next_s.phase      = PH_DISCHARGE;
          end else begin
            next_s.timerCount = s.timerCount + CNT1_W'(1);
          end
        end
      end
      // Discharge: count fast ticks until the comparator falls
      PH_DISCHARGE: begin
        if (fastTick && s.timerCount != {CNT1_W{1'b1}}) begin         // R6
          next_s.timerCount = s.timerCount + CNT1_W'(1);
        end
        // A stuck comparator saturates the count so the cycle still ends
        if ((s.compPrev && !comparatorOutput) || s.timerCount == {CNT1_W{1'b1}}) begin
          next_s.capTime[s.chan] = s.timerCount;                      // R13
          next_s.timerCount      = '0;
          if (s.chan == CH_REF) begin
            next_s.lightSleep = 1'b0;                                 // R7
            next_s.divSel     = 1'b0;
            next_s.divStep    = '0;
            next_s.divRem     = '0;
            next_s.divQuo     = DIV_W'(RREF_SCALED * DIV_W'(s.capTime[CH_THERM])); // R14
            next_s.phase      = PH_DIVIDE;
          end else begin
            next_s.chan  = s.chan + 2'h1;                             // R8
            next_s.phase = PH_CHARGE;
          end
        end
      end
      // Restoring divide, one quotient bit per cycle
      PH_DIVIDE: begin
        trial = {s.divRem, s.divQuo[DIV_W-1]};
        next_s.divQuo = {s.divQuo[DIV_W-2:0], 1'b0};
        if (trial >= {1'b0, s.capTime[CH_REF]}) begin
          trial = trial - {1'b0, s.capTime[CH_REF]};
          next_s.divQuo[0] = 1'b1;
        end
        next_s.divRem  = trial[CNT1_W-1:0];
        next_s.divStep = s.divStep + 5'h1;
        if (s.divStep == 5'(DIV_W - 1)) begin
          quo16 = (|next_s.divQuo[DIV_W-1:RES_W]) ? {RES_W{1'b1}} : next_s.divQuo[RES_W-1:0];
          if (s.capTime[CH_REF] == '0) begin
            quo16 = {RES_W{1'b1}};
          end
          next_s.divStep = '0;
          next_s.divRem  = '0;
          if (!s.divSel) begin
            next_s.rTherm = quo16;                                    // R10 R14
            next_s.divSel = 1'b1;
            next_s.divQuo = DIV_W'(RREF_SCALED * DIV_W'(s.capTime[CH_POT]));
          end else begin
            next_s.rPot    = quo16;                                   // R10 R14
            next_s.lookIdx = '0;
            next_s.phase   = PH_LOOKUP;
          end
        end
      end
      // Walk the table until the resistance reaches the entry
      PH_LOOKUP: begin
        if (s.rTherm >= s.ntcTable[s.lookIdx] || s.lookIdx == 6'(TABLE_LEN - 1)) begin
          next_s.tempF = TEMP_BASE_F + 8'(s.lookIdx);                 // R9
          potDiff = (s.rPot > SETPT_OFFSET) ? s.rPot - SETPT_OFFSET : '0;
          potDiff = potDiff >> SETPT_SHIFT;                           // R11
          steps = (potDiff > RES_W'(SETPT_MAX_F - SETPT_BASE_F)) ?
                  (SETPT_MAX_F - SETPT_BASE_F) : potDiff[7:0];
          next_s.setF  = SETPT_BASE_F + steps;                        // R11
          next_s.phase = PH_DECIDE;
        end else begin
          next_s.lookIdx = s.lookIdx + 6'h1;
        end
      end
      // Hold band of one degree keeps heat and cool from chattering
      PH_DECIDE: begin
        next_s.led.sysOn = 1'b1;                                      // R3
        next_s.led.cool  = {1'b0, s.tempF} > ({1'b0, s.setF} + {1'b0, TOL_F});   // R4
        next_s.led.heat  = ({1'b0, s.tempF} + {1'b0, TOL_F}) < {1'b0, s.setF};   // R4
        next_s.chan0Count = '0;
        next_s.deepSleep  = 1'b1;
        next_s.phase      = PH_LED_HOLD;
      end
      // Indicators held on while channel zero times half a second
      PH_LED_HOLD: begin
        if (slowTick) begin                                           // R5 R6
          if (s.chan0Count >= CNT0_W'(LED_TICKS_P - 1)) begin
            next_s.led        = '0;                                   // R2
            next_s.chan0Count = '0;
            next_s.phase      = PH_DEEP_WAIT;                         // R1
          end else begin
            next_s.chan0Count = s.chan0Count + CNT0_W'(1);
          end
        end
      end
      default: begin
        next_s.phase = PH_DEEP_WAIT;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // APB answers with no wait states; data and error come from flops
  assign apbRsp.prdata  = s.rdData;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = s.slvErr;

  // Pin drive: idle keeps the drive line high and every sense line released
  always_comb begin
    pins.driveLine = (s.phase != PH_DISCHARGE);                       // R12 R13
    pins.sensOut   = '0;
    pins.sensOeN   = '1;                                              // R12
    if (s.phase == PH_CHARGE || s.phase == PH_DISCHARGE) begin
      pins.sensOeN[s.chan] = 1'b0;
      pins.sensOut[s.chan] = (s.phase == PH_CHARGE);                  // R13
    end
  end

  assign leds = s.led;
endmodule

// file: testbench/thr_slope_sva.sv
// Purpose: Port-level checker for the slope thermostat controller
// Assumes: Single core_clk domain, nrst asynchronous active low
// Notes:   LED hold window allows one slow tick of phase slack either side
`timescale 1ns/1ps
module thr_slope_sva
  import thr_pkg::*;
#(
  parameter int unsigned LED_TICKS_P = 16384,
  parameter int unsigned SLOW_DIV_P  = 7629
) (
  // Clock and reset
  input wire logic                  core_clk,
  input wire logic                  nrst,
  // Watched pins
  input wire logic                  comparatorOutput,
  input wire thr_pkg::thr_pins_type pins,
  input wire thr_pkg::thr_led_type  leds
);
  import thr_pkg::*;
  localparam int unsigned LED_LO = (LED_TICKS_P - 1) * SLOW_DIV_P;
  localparam int unsigned LED_HI = (LED_TICKS_P + 1) * SLOW_DIV_P + 1;
  logic [31:0] ledCnt;
  logic [31:0] dischCnt;

  // Length of the current indicator burst and of the current discharge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ledCnt   <= 32'h0;
      dischCnt <= 32'h0;
    end else begin
      ledCnt   <= leds.sysOn ? ledCnt + 32'h1 : 32'h0;
      dischCnt <= pins.driveLine ? 32'h0 : dischCnt + 32'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  pins_idle_a: assert property (pins.sensOeN == 3'h7 |-> pins.driveLine && pins.sensOut == 3'h0)
    else $error("Idle sense lines not released");
  disch_select_a: assert property (!pins.driveLine |-> $onehot(~pins.sensOeN) && pins.sensOut == 3'h0)
    else $error("Discharge without exactly one low sense line");
  charge_high_a: assert property (pins.driveLine && pins.sensOeN != 3'h7
      |-> $onehot(~pins.sensOeN) && pins.sensOut == ~pins.sensOeN)
    else $error("Charging line not driven high");
  disch_end_a: assert property (!pins.driveLine && $fell(comparatorOutput) |-> ##[1:2] pins.driveLine)
    else $error("Discharge did not end on comparator fall");
  disch_wait_a: assert property ($rose(pins.driveLine)
      |-> !$past(comparatorOutput) || dischCnt >= 32'd65535)
    else $error("Discharge ended before comparator fall");
  leds_excl_a: assert property (leds.heat || leds.cool |-> leds.sysOn && !(leds.heat && leds.cool))
    else $error("Heat or cool without system on, or both");
  leds_quiet_a: assert property (leds.sysOn |-> pins.sensOeN == 3'h7 && pins.driveLine)
    else $error("Indicators on during measurement");
  leds_steady_a: assert property (leds.sysOn && $past(leds.sysOn) |-> $stable(leds))
    else $error("Indicators changed during hold");
  led_hold_a: assert property ($fell(leds.sysOn) |-> ledCnt >= LED_LO && ledCnt <= LED_HI)
    else $error("Indicator hold length wrong");
endmodule

bind thr_slope_ctrl thr_slope_sva #(.LED_TICKS_P(LED_TICKS_P), .SLOW_DIV_P(SLOW_DIV_P))
  i_thr_slope_sva (.core_clk(core_clk), .nrst(nrst), .comparatorOutput(comparatorOutput),
                   .pins(pins), .leds(leds));

// file: testbench/thr_rc_model.sv
// Purpose: Behavioural resistor network, capacitor, comparator and pull-ups
// Assumes: Discharge times given in fast ticks of TICK_CYC core cycles
// Notes:   Comparator high whenever charged; released lines read the pull-up
`timescale 1ns/1ps
module thr_rc_model
  import thr_pkg::*;
#(
  parameter int unsigned TICK_CYC = 2
) (
  // Clock
  input  wire logic                  core_clk,
  // Discharge times per channel
  input  wire logic [15:0]           tTherm,
  input  wire logic [15:0]           tPot,
  input  wire logic [15:0]           tRef,
  // Network side
  input  wire thr_pkg::thr_pins_type pins,
  output logic [thr_pkg::NUM_CH-1:0] sensIn,
  output logic                       comparatorOutput
);
  import thr_pkg::*;
  logic [31:0] lowCnt;
  logic [15:0] tSel;

  // Each resistor has its own discharge time
  always_comb begin
    case (pins.sensOeN)
      3'h6:    tSel = tTherm;
      3'h5:    tSel = tPot;
      3'h3:    tSel = tRef;
      default: tSel = 16'hFFFF;
    endcase
  end

  // Time spent discharging
  always_ff @(posedge core_clk) begin
    lowCnt <= pins.driveLine ? 32'h0 : lowCnt + 32'h1;
  end

  assign sensIn           = pins.sensOeN | pins.sensOut;
  assign comparatorOutput = pins.driveLine || (lowCnt < TICK_CYC * tSel);
endmodule

// file: testbench/tb_top.sv
// Purpose: Register and decision test of the slope thermostat controller
// Assumes: Shortened wake, hold, charge and tick dividers
// Notes:   Times chosen so capture slack of one tick cannot move a result
`timescale 1ns/1ps
module tb_top;
  import thr_pkg::*;
  localparam int unsigned LIMIT = 40000;
  logic            core_clk = 1'b0;
  logic            nrst;
  thr_apb_req_type apbReq;
  thr_apb_rsp_type apbRsp;
  logic [2:0]      sensIn;
  logic            comparatorOutput;
  thr_pins_type    pins;
  thr_led_type     leds;
  logic [15:0]     tTherm;
  logic [15:0]     tPot;
  logic [15:0]     tRef;
  logic [31:0]     rd;
  logic            err;
  int              failures = 0;
  int              n_tests = 0;
  int              cycles = 0;
  int              t0;
  // Per row: pot time, setpoint, temperature, {heat, cool}
  logic [15:0] potT [7] = '{16'h0182, 16'h0172, 16'h0162, 16'h01A2, 16'h0320, 16'h0078, 16'h01E2};
  logic [7:0]  setE [7] = '{8'h4D, 8'h4C, 8'h4B, 8'h4F, 8'h5A, 8'h41, 8'h4D};
  logic [7:0]  tmpE [7] = '{8'h4D, 8'h4D, 8'h4D, 8'h4D, 8'h4D, 8'h4D, 8'h46};
  logic [1:0]  hcE  [7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2};

  thr_slope_ctrl #(.WAKE_TICKS_P(20), .LED_TICKS_P(5), .CHARGE_TICKS_P(4), .SLOW_DIV_P(3),
    .FAST_DIV_P(2)) i_thr_slope_ctrl (.core_clk(core_clk), .nrst(nrst), .apbReq(apbReq),
    .apbRsp(apbRsp), .sensIn(sensIn), .comparatorOutput(comparatorOutput), .pins(pins),
    .leds(leds));
  thr_rc_model i_thr_rc_model (.core_clk(core_clk), .tTherm(tTherm),
    .tPot(tPot), .tRef(tRef), .pins(pins), .sensIn(sensIn),
    .comparatorOutput(comparatorOutput));

  always #2 core_clk = ~core_clk;

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report();
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] lo, input logic [31:0] hi,
                     input logic [31:0] got);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("Error %s expected %h..%h seen %h", name, lo, hi, got);
    end
  endtask

  // One APB transfer; waits for pready, takes data at that edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge core_clk);
    apbReq <= '{paddr: addr, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wdata};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do @(posedge core_clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  initial begin
    apbReq = '0;
    nrst = 1'b0;
    tTherm = 16'h0258;
    tRef = 16'h0190;
    tPot = potT[0];
    repeat (20) @(posedge core_clk);
    chk("reset pins", 32'h47, 32'h47, 32'(pins));
    chk("reset leds", 32'h0, 32'h0, 32'(leds));
    nrst <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h1, 32'h1, rd);
    apb(1'b0, REG_TABLE, 32'h0);
    chk("table first", 32'hC8, 32'hC8, rd);
    apb(1'b0, REG_TABLE + 12'h08C, 32'h0);
    chk("table last", 32'h5F, 32'h5F, rd);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", 32'h1, 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, 32'h0, rd);
    apb(1'b1, REG_TABLE + 12'h014, 32'hFFFF1234);
    apb(1'b0, REG_TABLE + 12'h014, 32'h0);
    chk("table rw", 32'h1234, 32'h1234, rd);
    // Decision rows: match, band edge, cool, heat, clamp high, clamp low, new table
    for (int r = 0; r < 7; r++) begin
      while (leds.sysOn !== 1'b1) @(negedge core_clk);
      chk("heat cool", 32'(hcE[r]), 32'(hcE[r]), {30'h0, leds.heat, leds.cool});
      while (leds.sysOn === 1'b1) @(negedge core_clk);
      t0 = cycles;
      if (r == 1) apb(1'b1, REG_CTRL, 32'h3);
      apb(1'b0, REG_RESULT, 32'h0);
      chk("temperature", 32'(tmpE[r]), 32'(tmpE[r]), 32'(rd[7:0]));
      chk("setpoint", 32'(setE[r]), 32'(setE[r]), 32'(rd[15:8]));
      if (r == 0) begin
        apb(1'b0, REG_RES, 32'h0);
        chk("thermistor res", 32'h95, 32'h97, 32'(rd[15:0]));
        apb(1'b0, REG_TIME1, 32'h0);
        chk("reference time", 32'h18F, 32'h191, 32'(rd[15:0]));
        apb(1'b0, REG_TIME0, 32'h0);
        chk("thermistor time", 32'h257, 32'h259, 32'(rd[15:0]));
        // Idle after a cycle: deep sleep, last channel, lines pulled up, comparator high
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status idle", 32'hF48, 32'hF48, rd);
      end
      if (r == 5) apb(1'b1, REG_TABLE + 12'h028, 32'h94);
      // Slower capacitor: every time grows by five quarters, so ratios stay put
      if (r == 5) begin
        tTherm <= 16'h02EE;
        tRef   <= 16'h01F4;
      end
      if (r < 6) begin
        tPot = potT[r + 1];
        while (pins.sensOeN[0] !== 1'b0) @(negedge core_clk);
        if (r == 1) chk("kick gap", 32'h0, 32'h14, 32'(cycles - t0));
        else chk("sleep gap", 32'h39, 32'h42, 32'(cycles - t0));
      end
    end
    final_report();
  end
endmodule
